// file: verilog/vgacfg_pkg.sv
// Package of constants and types for the variable-gain die configuration bank
package vgacfg_pkg;

    // Register port widths
    localparam int unsigned VGACFG_ADDR_W = 8;
    localparam int unsigned VGACFG_DATA_W = 16;

    // Register addresses
    localparam logic [7:0] VGACFG_ADDR_FILTER = 8'hc7;
    localparam logic [7:0] VGACFG_ADDR_REDUCED_POWER_SEL = 8'hc8;
    localparam logic [7:0] VGACFG_ADDR_BIAS = 8'hca;
    localparam logic [7:0] VGACFG_ADDR_MED_POW = 8'hce;
    localparam logic [7:0] VGACFG_ADDR_STATUS = 8'hd0;

    // Reset value shared by every register
    localparam logic [15:0] VGACFG_REG_RESET = 16'h0000;

    // Field positions
    localparam int unsigned VGACFG_HPF_LSB = 10;
    localparam int unsigned VGACFG_HPF_MSB = 11;
    localparam int unsigned VGACFG_HPF_BYP_BIT = 9;
    localparam int unsigned VGACFG_LPF_LSB = 7;
    localparam int unsigned VGACFG_LPF_MSB = 8;
    localparam int unsigned VGACFG_REDUCED_POWER_SEL_BIT = 12;
    localparam int unsigned VGACFG_BIAS_BIT = 10;
    localparam int unsigned VGACFG_MED_POW_BIT = 14;

    // Assigned bits of each register; the rest are storage only
    localparam logic [15:0] VGACFG_FILTER_MASK = 16'h0f80;
    localparam logic [15:0] VGACFG_REDUCED_POWER_SEL_MASK = 16'h1000;
    localparam logic [15:0] VGACFG_BIAS_MASK = 16'h0400;
    localparam logic [15:0] VGACFG_MED_POW_MASK = 16'h4000;

    // Status register fields
    localparam int unsigned VGACFG_ST_CW_BIT = 0;
    localparam int unsigned VGACFG_ST_PWR_LSB = 1;
    localparam int unsigned VGACFG_ST_PWR_MSB = 2;
    localparam int unsigned VGACFG_ST_BIAS_BIT = 3;
    localparam int unsigned VGACFG_ST_HPF_BIT = 4;
    localparam int unsigned VGACFG_ST_RSVD_BIT = 8;

    // High-pass cutoff in kHz, indexed by code
    localparam logic [9:0] VGACFG_HPF_KHZ [4] = '{10'h04b, 10'h096, 10'h12c, 10'h258};
    // Low-pass cutoff in units of 100 kHz, low-noise and medium power
    localparam logic [7:0] VGACFG_LPF_NORM [4] = '{8'h96, 8'h64, 8'hfa, 8'hc8};
    // Low-pass cutoff in units of 100 kHz, low power
    localparam logic [7:0] VGACFG_LPF_LOW [4] = '{8'h4b, 8'h32, 8'h7d, 8'h64};

    typedef enum logic [1:0] {
        VGACFG_PWR_LOW_NOISE = 2'b00,
        VGACFG_PWR_MEDIUM = 2'b01,
        VGACFG_PWR_LOW = 2'b10
    } vgacfg_pwr_mode_t;

    typedef struct packed {
        logic [1:0] hpf_code;
        logic [9:0] hpf_khz;
        logic hpf_enable;
        logic [1:0] lpf_code;
        logic [7:0] lpf_100khz;
        vgacfg_pwr_mode_t pwr_mode;
        logic fixed_bias_en;
    } vgacfg_settings_t;

endpackage

// file: verilog/vgacfg_reg16.sv
// One 16-bit read/write configuration register with zero reset
`timescale 1ns/1ps
module vgacfg_reg16
    import vgacfg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Write side
    input wire logic wr_en,
    input wire logic [15:0] wdata,
    // Stored value
    output logic [15:0] q
);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= VGACFG_REG_RESET;
        end else if (wr_en) begin
            q <= wdata;
        end
    end

endmodule // vgacfg_reg16

// file: verilog/vgacfg_decode.sv
// Turns the stored register words into registered signal-path settings
`timescale 1ns/1ps
module vgacfg_decode
    import vgacfg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Stored words and mode
    input wire logic [15:0] filter_word,
    input wire logic [15:0] reduced_power_sel_word,
    input wire logic [15:0] bias_word,
    input wire logic [15:0] med_pow_word,
    input wire logic cw_mode,
    // Decoded settings
    output vgacfg_settings_t settings_q
);

    vgacfg_settings_t settings_d;
    wire logic [1:0] hpf_code = filter_word[VGACFG_HPF_MSB:VGACFG_HPF_LSB];
    wire logic [1:0] lpf_code = filter_word[VGACFG_LPF_MSB:VGACFG_LPF_LSB];
    wire logic low_req = reduced_power_sel_word[VGACFG_REDUCED_POWER_SEL_BIT];
    wire logic med_req = med_pow_word[VGACFG_MED_POW_BIT];
    wire logic bias_req = bias_word[VGACFG_BIAS_BIT];
    // Power selects act only in time-gain mode; low power overrides medium
    wire logic low_act = low_req && !cw_mode; // R5
    wire logic med_act = med_req && !low_req && !cw_mode; // R11
    wire vgacfg_pwr_mode_t pwr_mode = low_act ? VGACFG_PWR_LOW :
        (med_act ? VGACFG_PWR_MEDIUM : VGACFG_PWR_LOW_NOISE);

    always_comb begin
        settings_d.hpf_code = hpf_code;
        settings_d.hpf_khz = VGACFG_HPF_KHZ[hpf_code]; // R1
        settings_d.hpf_enable = !filter_word[VGACFG_HPF_BYP_BIT]; // R2
        settings_d.lpf_code = lpf_code;
        if (pwr_mode == VGACFG_PWR_LOW) begin
            settings_d.lpf_100khz = VGACFG_LPF_LOW[lpf_code]; // R3 R4
        end else begin
            settings_d.lpf_100khz = VGACFG_LPF_NORM[lpf_code]; // R3 R4
        end
        settings_d.pwr_mode = pwr_mode;
        settings_d.fixed_bias_en = bias_req && !cw_mode; // R6 R7
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            settings_q <= '0;
        end else begin
            settings_q <= settings_d;
        end
    end

endmodule // vgacfg_decode

// file: verilog/vgacfg_bank.sv
// Configuration register bank of the variable-gain die signal path
//
// Contract
// R1: High-pass cutoff code gives 75 to 600 kHz
// R2: Bypass bit set disables the high-pass filter
// R3: Low-pass codes 00/01 halve in low power
// R4: Low-pass codes 10/11 halve in low power
// R5: Reduced-power bit selects low power, time-gain only
// R6: Fixed-bias bit gives constant current in time-gain
// R7: Fixed-bias bit ignored in continuous-wave mode
// R8: All bank bits read/write, reset to zero
// R9: Mid-power bit at 14 of CEh
// R10: Software writes unassigned bits as zero
// R11: Mid-power works only with reduced-power clear
// R12: Filter fields live in register C7h
`timescale 1ns/1ps
module vgacfg_bank
    import vgacfg_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Mode pin, high in continuous-wave mode
    input wire logic continuous_wave_mode,
    // Settings to the analog signal path
    output vgacfg_settings_t settings
);

    // Mode pin synchroniser
    logic cw_meta_q;
    logic cw_sync_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cw_meta_q <= 1'b0;
            cw_sync_q <= 1'b0;
        end else begin
            cw_meta_q <= continuous_wave_mode;
            cw_sync_q <= cw_meta_q;
        end
    end

    // Address decode
    wire logic hit_filter = (reg_addr == VGACFG_ADDR_FILTER); // R12
    wire logic hit_reduced_power_sel = (reg_addr == VGACFG_ADDR_REDUCED_POWER_SEL);
    wire logic hit_bias = (reg_addr == VGACFG_ADDR_BIAS);
    wire logic hit_med_pow = (reg_addr == VGACFG_ADDR_MED_POW); // R9
    wire logic hit_status = (reg_addr == VGACFG_ADDR_STATUS);
    wire logic hit_bank = hit_filter || hit_reduced_power_sel || hit_bias || hit_med_pow;

    // Write strobes, one per register
    wire logic wr_filter = reg_wr && hit_filter;
    wire logic wr_reduced_power_sel = reg_wr && hit_reduced_power_sel;
    wire logic wr_bias = reg_wr && hit_bias;
    wire logic wr_med_pow = reg_wr && hit_med_pow;
    wire logic wr_status = reg_wr && hit_status;

    // Stored words
    logic [15:0] filter_word;
    logic [15:0] reduced_power_sel_word;
    logic [15:0] bias_word;
    logic [15:0] med_pow_word;

    // Every bit is stored, including unassigned ones
    vgacfg_reg16 u_filter_reg ( // R8
        .clk(ref_clk),
        .rst(rst),
        .wr_en(wr_filter),
        .wdata(reg_wdata),
        .q(filter_word)
    );

    vgacfg_reg16 u_reduced_power_sel_reg ( // R8
        .clk(ref_clk),
        .rst(rst),
        .wr_en(wr_reduced_power_sel),
        .wdata(reg_wdata),
        .q(reduced_power_sel_word)
    );

    vgacfg_reg16 u_bias_reg ( // R8
        .clk(ref_clk),
        .rst(rst),
        .wr_en(wr_bias),
        .wdata(reg_wdata),
        .q(bias_word)
    );

    vgacfg_reg16 u_med_pow_reg ( // R8 R9
        .clk(ref_clk),
        .rst(rst),
        .wr_en(wr_med_pow),
        .wdata(reg_wdata),
        .q(med_pow_word)
    );

    // Decoded settings, registered inside the decoder
    vgacfg_settings_t settings_q;

    vgacfg_decode u_decode (
        .clk(ref_clk),
        .rst(rst),
        .filter_word(filter_word),
        .reduced_power_sel_word(reduced_power_sel_word),
        .bias_word(bias_word),
        .med_pow_word(med_pow_word),
        .cw_mode(cw_sync_q),
        .settings_q(settings_q)
    );

    assign settings = settings_q;

    // Mask of assigned bits for the register being written
    wire logic [15:0] used_mask =
        hit_filter ? VGACFG_FILTER_MASK :
        hit_reduced_power_sel ? VGACFG_REDUCED_POWER_SEL_MASK :
        hit_bias ? VGACFG_BIAS_MASK :
        hit_med_pow ? VGACFG_MED_POW_MASK : 16'hffff;

    // Nonzero data written to unassigned bits is stored but flagged
    wire logic rsvd_hit = reg_wr && hit_bank && ((reg_wdata & ~used_mask) != 16'h0000); // R10
    wire logic rsvd_clr = wr_status && reg_wdata[VGACFG_ST_RSVD_BIT];

    logic rsvd_wr_q;
    logic rsvd_wr_d;

    // A new event in the clearing cycle keeps the flag set
    assign rsvd_wr_d = rsvd_hit ? 1'b1 : (rsvd_clr ? 1'b0 : rsvd_wr_q);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rsvd_wr_q <= 1'b0;
        end else begin
            rsvd_wr_q <= rsvd_wr_d;
        end
    end

    // Status word shows the effective state of the signal path
    logic [15:0] status_word;

    always_comb begin
        status_word = 16'h0000;
        status_word[VGACFG_ST_CW_BIT] = cw_sync_q;
        status_word[VGACFG_ST_PWR_MSB:VGACFG_ST_PWR_LSB] = settings_q.pwr_mode;
        status_word[VGACFG_ST_BIAS_BIT] = settings_q.fixed_bias_en;
        status_word[VGACFG_ST_HPF_BIT] = settings_q.hpf_enable;
        status_word[VGACFG_ST_RSVD_BIT] = rsvd_wr_q;
    end

    // Read selection; unmapped addresses read zero
    wire logic [15:0] rd_sel =
        hit_filter ? filter_word :
        hit_reduced_power_sel ? reduced_power_sel_word :
        hit_bias ? bias_word :
        hit_med_pow ? med_pow_word :
        hit_status ? status_word : 16'h0000;

    // Read data stand for the one cycle after the read strobe
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;

    assign rdata_d = reg_rd ? rd_sel : 16'h0000; // R8

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= VGACFG_REG_RESET;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

endmodule // vgacfg_bank

// file: sim/vgacfg_bank_assertions.sv
// Port checker of the configuration bank
`timescale 1ns/1ps
module vgacfg_bank_chk
    import vgacfg_pkg::*;
(
    // Bank ports
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic continuous_wave_mode,
    input wire vgacfg_settings_t settings
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire wr_map = reg_wr && (reg_addr inside {8'hc7, 8'hc8, 8'hca, 8'hce});
    wire wr_flt = reg_wr && reg_addr == VGACFG_ADDR_FILTER;
    wire wr_low = reg_wr && reg_addr == VGACFG_ADDR_REDUCED_POWER_SEL;
    wire wr_bias = reg_wr && reg_addr == VGACFG_ADDR_BIAS;
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 16'h0000;
    endproperty
    property p_rd_back;
        wr_map ##1 (reg_rd && !reg_wr && reg_addr == $past(reg_addr)) |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    property p_hpf;
        wr_flt ##1 !wr_flt |=> settings.hpf_code == $past(reg_wdata[11:10], 2)
            && settings.hpf_khz == VGACFG_HPF_KHZ[settings.hpf_code];
    endproperty
    property p_byp;
        wr_flt ##1 !wr_flt |=> settings.hpf_enable == !$past(reg_wdata[9], 2);
    endproperty
    property p_lpf;
        !$past(rst) |-> settings.lpf_100khz == (settings.pwr_mode == VGACFG_PWR_LOW ?
            VGACFG_LPF_LOW[settings.lpf_code] : VGACFG_LPF_NORM[settings.lpf_code]);
    endproperty
    property p_low;
        (!continuous_wave_mode)[*4] ##0 (wr_low && reg_wdata[12]) ##1 !wr_low |=> settings.pwr_mode == VGACFG_PWR_LOW;
    endproperty
    property p_bias;
        (!continuous_wave_mode)[*4] ##0 wr_bias ##1 !wr_bias |=> settings.fixed_bias_en == $past(reg_wdata[10], 2);
    endproperty
    property p_cw;
        continuous_wave_mode[*4] |-> !settings.fixed_bias_en && settings.pwr_mode == VGACFG_PWR_LOW_NOISE;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read");
    a_rd_back: assert property (p_rd_back) else $error("read back differs from write");
    a_hpf: assert property (p_hpf) else $error("high-pass cutoff wrong");
    a_byp: assert property (p_byp) else $error("high-pass bypass wrong");
    a_lpf: assert property (p_lpf) else $error("low-pass cutoff wrong for power mode");
    a_low: assert property (p_low) else $error("reduced power not applied");
    a_bias: assert property (p_bias) else $error("fixed bias not applied");
    a_cw: assert property (p_cw) else $error("power or bias select active in continuous wave");
    c_rd_back: cover property (wr_map ##1 reg_rd);
    c_medium: cover property (settings.pwr_mode == VGACFG_PWR_MEDIUM);
    c_cw: cover property (continuous_wave_mode[*4] ##1 !continuous_wave_mode);
endmodule // vgacfg_bank_chk

bind vgacfg_bank vgacfg_bank_chk vgacfg_bank_chk_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .continuous_wave_mode(continuous_wave_mode), .settings(settings));

// file: sim/testbench.sv
// Self-checking testbench of the configuration bank
`timescale 1ns/1ps
module testbench
    import vgacfg_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic cw_mode = 1'b0;
    logic [15:0] reg_rdata;
    vgacfg_settings_t settings;
    logic [15:0] mem [256];
    logic [7:0] amap [4] = '{8'hc7, 8'hc8, 8'hca, 8'hce};
    logic [31:0] seed = 32'h07eb;
    logic [31:0] r;
    int miscompares = 0;
    int cmp_count = 0;
    logic rsvd_exp = 1'b0;

    always #12.5 ref_clk = ~ref_clk;

    vgacfg_bank vgacfg_bank_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .continuous_wave_mode(cw_mode),
        .settings(settings));

    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Expected settings from the shadow registers and the mode pin
    function automatic vgacfg_settings_t exp_set();
        logic lo;
        logic [7:0] nrm;
        vgacfg_settings_t e;
        lo = !cw_mode && mem[8'hc8][12];
        e.hpf_code = mem[8'hc7][11:10];
        e.hpf_khz = 10'h04b << e.hpf_code;
        e.hpf_enable = !mem[8'hc7][9];
        e.lpf_code = mem[8'hc7][8:7];
        nrm = e.lpf_code[0] ? (e.lpf_code[1] ? 8'hc8 : 8'h64) : (e.lpf_code[1] ? 8'hfa : 8'h96);
        e.lpf_100khz = lo ? nrm >> 1 : nrm;
        e.pwr_mode = lo ? VGACFG_PWR_LOW : (!cw_mode && mem[8'hce][14]) ? VGACFG_PWR_MEDIUM : VGACFG_PWR_LOW_NOISE;
        e.fixed_bias_en = !cw_mode && mem[8'hca][10];
        return e;
    endfunction

    // Bits that carry a function in each mapped register
    function automatic logic [15:0] used_bits(input logic [7:0] a);
        case (a)
            VGACFG_ADDR_FILTER: return VGACFG_FILTER_MASK;
            VGACFG_ADDR_REDUCED_POWER_SEL: return VGACFG_REDUCED_POWER_SEL_MASK;
            VGACFG_ADDR_BIAS: return VGACFG_BIAS_MASK;
            VGACFG_ADDR_MED_POW: return VGACFG_MED_POW_MASK;
            default: return 16'hffff;
        endcase
    endfunction

    // Expected read data: shadow word, or status built from the expected settings
    function automatic logic [15:0] exp_rd(input logic [7:0] a);
        vgacfg_settings_t e;
        logic [15:0] s;
        e = exp_set();
        s = 16'h0000;
        s[VGACFG_ST_CW_BIT] = cw_mode;
        s[VGACFG_ST_PWR_MSB:VGACFG_ST_PWR_LSB] = e.pwr_mode;
        s[VGACFG_ST_BIAS_BIT] = e.fixed_bias_en;
        s[VGACFG_ST_HPF_BIT] = e.hpf_enable;
        s[VGACFG_ST_RSVD_BIT] = rsvd_exp;
        return (a == VGACFG_ADDR_STATUS) ? s : mem[a];
    endfunction

    task check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Called just after a rising edge; returns just after one
    task rd(input logic [7:0] a);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check(32'(reg_rdata), 32'(exp_rd(a)));
        @(posedge ref_clk);
    endtask

    task wrrd(input logic [7:0] a, input logic [15:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        if (a inside {8'hc7, 8'hc8, 8'hca, 8'hce}) mem[a] = d;
        if ((d & ~used_bits(a)) != 16'h0000) rsvd_exp = 1'b1;
        if (a == VGACFG_ADDR_STATUS && d[VGACFG_ST_RSVD_BIT]) rsvd_exp = 1'b0;
        rd(a);
    endtask

    task chk_set();
        repeat (4) @(posedge ref_clk);
        #1 check(32'(settings), 32'(exp_set()));
        @(posedge ref_clk);
    endtask

    task do_reset();
        rst <= 1'b1;
        foreach (mem[i]) mem[i] = 16'h0000;
        rsvd_exp = 1'b0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        foreach (amap[i]) rd(amap[i]);
        rd(8'h3c);
        chk_set();
        rd(VGACFG_ADDR_STATUS);
    endtask

    task finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        finish_test();
    end

    initial begin
        do_reset();
        $display("reset test done");
        for (int k = 0; k < 2; k++) begin
            for (int c = 0; c < 4; c++) begin
                for (int p = 0; p < 4; p++) begin
                    cw_mode <= k[0];
                    wrrd(8'hc7, {4'h0, c[1:0], c[0], c[1:0], 7'h00});
                    wrrd(8'hc8, {3'h0, p[1], 12'h000});
                    wrrd(8'hce, {1'b0, p[0], 14'h0000});
                    wrrd(8'hca, {5'h00, c[1], 10'h000});
                    chk_set();
                    rd(VGACFG_ADDR_STATUS);
                end
            end
        end
        $display("sweep test done");
        repeat (40) begin
            r = xs();
            cw_mode <= r[2];
            wrrd(r[3] ? amap[r[1:0]] : {2'b00, r[9:4]}, r[31:16]);
            chk_set();
            rd(VGACFG_ADDR_STATUS);
        end
        wrrd(VGACFG_ADDR_STATUS, 16'h0100);
        $display("random test done");
        do_reset();
        $display("second reset test done");
        finish_test();
    end
endmodule // testbench
